// [hdl/scc_center.sv]
// Scan center: host memory, per-satellite command handling and status pins.
// How it works
// R1 - Third consecutive miss sets third-miss flag.
// R2 - Third miss fires fixed-length pulse pin.
// R3 - Output word sent every scan, any command.
// R4 - One response word stored per satellite scan with a good response.
// R5 - Commands map to input or result areas.
// R6 - Control at 2*SA, input data +100h.
// R7 - Result areas spaced 80h per area.
// R8 - Auto-clear returns counter command to zero.
// R9 - Identity command runs once, then zero.
// R10 - Counter-clear stores 0000h in result word.
// R11 - Auto-round advances command each completion.
// R12 - Value 30h rounds commands once, rests.
// R13 - Satellite request sets request flag.
// R14 - Writing 00h at 480h drops request pin.
// R15 - Function command clears request flag.
// R16 - Host keeps command zero for basic satellites.
// R17 - Host splits wide values on byte bus.
// R18 - Host allows for scan-complete interrupt latency.
// R19 - Control bits 0-3 hold the command.
// R20 - Bit 4 auto-clear, cleared on completion.
// R21 - Bit 5 auto-round cycles commands 0-6.
// R22 - Bit 8 holds satellite request flag.
`timescale 1ns/10ps
module scc_center (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [10:0] i_ua,
  input wire logic [15:0] i_ud,
  output logic [15:0] o_ud,
  output logic o_ud_oe_n,
  input wire logic i_ucs_n,
  input wire logic i_urd_n,
  input wire logic i_uwr_n,
  output logic o_ack,
  input wire logic i_scan_run,
  output logic o_tx_valid,
  output logic [5:0] o_tx_sa,
  output logic [3:0] o_tx_cmd,
  output logic [15:0] o_tx_do,
  input wire logic i_rx_done,
  input wire logic i_rx_ok,
  input wire logic [15:0] i_rx_data,
  input wire logic i_rx_satellite_request_flag,
  output logic o_scan_read_done,
  output logic o_third_miss_pulse_pin,
  output logic o_satellite_request
);
  logic [15:0] mem [scc_pkg::MEM_WORDS];
  scc_pkg::scc_state_e state_reg;
  scc_pkg::scc_state_e state_next;
  logic [5:0] sa_reg;
  logic rx_ok_reg;
  logic rx_satellite_request_flag_reg;
  logic [15:0] rx_data_reg;
  logic wr_act_reg;
  logic [10:0] wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic [7:0] pulse_cnt_reg;

  // Host bus decode; a write commits when its strobe pair ends.
  wire rd_act = !i_ucs_n && !i_urd_n;
  wire wr_act = !i_ucs_n && !i_uwr_n;
  wire host_commit = wr_act_reg && !wr_act;
  wire [9:0] wr_widx = wr_addr_reg[10:1];
  wire [9:0] rd_widx = i_ua[10:1];
  wire rd_mapped = 32'(rd_widx) < scc_pkg::MEM_WORDS;
  wire wr_mapped = 32'(wr_widx) < scc_pkg::MEM_WORDS;
  // R14 request output reset location.
  wire req_reset_wr = host_commit && (wr_addr_reg == scc_pkg::REQ_RESET_ADDR) &&
    (wr_data_reg[7:0] == scc_pkg::REQ_RESET_DATA);
  wire host_mem_wr = host_commit && wr_mapped && (wr_addr_reg != scc_pkg::REQ_RESET_ADDR);

  // R6 R19 control and output words of the current satellite.
  wire [9:0] ctrl_widx = scc_pkg::CTRL_BASE_W + {4'h0, sa_reg};
  wire [9:0] do_widx = scc_pkg::DO_BASE_W + {4'h0, sa_reg};
  wire [15:0] ctrl_cur = mem[ctrl_widx];
  wire [15:0] do_cur = mem[do_widx];
  // R5 R6 R7 result area: 0 is input data, 1..7 are result areas.
  wire [2:0] area = o_tx_cmd[2:0];
  wire [9:0] res_widx = scc_pkg::DI_BASE_W + {1'b0, area, 6'h00} + {4'h0, sa_reg};
  // R10 counter-clear commands store a cleared word.
  wire clr_cmd = (o_tx_cmd >= scc_pkg::CMD_CLR_FIRST) &&
    (o_tx_cmd <= scc_pkg::CMD_CLR_LAST);
  wire [15:0] res_wdata = clr_cmd ? scc_pkg::CLEARED_WORD : rx_data_reg;
  // Scan writes wait one cycle when the host commits a write.
  wire store_go = (state_reg == scc_pkg::SCC_STORE) && !host_commit;
  wire last_sa = sa_reg == scc_pkg::SAT_LAST;
  wire [15:0] ctrl_new;
  wire third_evt;
  wire pulse_busy = pulse_cnt_reg != '0;

  scc_ctrl_update u_ctrl_update (
    .i_ctrl(ctrl_cur),
    .i_resp_ok(rx_ok_reg),
    .i_resp_satellite_request_flag(rx_satellite_request_flag_reg),
    .o_ctrl(ctrl_new),
    .o_third_event(third_evt)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      scc_pkg::SCC_IDLE: begin
        if (i_scan_run) begin
          state_next = scc_pkg::SCC_ISSUE;
        end
      end
      scc_pkg::SCC_ISSUE: begin
        state_next = scc_pkg::SCC_WAIT;
      end
      scc_pkg::SCC_WAIT: begin
        if (i_rx_done) begin
          state_next = scc_pkg::SCC_STORE;
        end
      end
      scc_pkg::SCC_STORE: begin
        if (store_go) begin
          state_next = (last_sa && !i_scan_run) ? scc_pkg::SCC_IDLE : scc_pkg::SCC_ISSUE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= scc_pkg::SCC_IDLE;
      sa_reg <= '0;
      o_scan_read_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_scan_read_done <= store_go && last_sa;
      if (state_reg == scc_pkg::SCC_IDLE) begin
        sa_reg <= '0;
      end else if (store_go) begin
        sa_reg <= sa_reg + 6'h01;
      end
    end
  end

  // R3 output word and command go out on every slot.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_sa <= '0;
      o_tx_cmd <= '0;
      o_tx_do <= '0;
    end else begin
      o_tx_valid <= state_reg == scc_pkg::SCC_ISSUE;
      if (state_reg == scc_pkg::SCC_ISSUE) begin
        o_tx_sa <= sa_reg;
        o_tx_cmd <= ctrl_cur[scc_pkg::CMD_LSB +: scc_pkg::CMD_W];
        o_tx_do <= do_cur;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_ok_reg <= 1'b0;
      rx_satellite_request_flag_reg <= 1'b0;
      rx_data_reg <= '0;
    end else if ((state_reg == scc_pkg::SCC_WAIT) && i_rx_done) begin
      rx_ok_reg <= i_rx_ok;
      rx_satellite_request_flag_reg <= i_rx_ok && i_rx_satellite_request_flag;
      rx_data_reg <= i_rx_data;
    end
  end

  // R4 one result word (good response only) and the control word per slot; host writes first.
  always_ff @(posedge i_core_clk) begin
    if (host_mem_wr) begin
      mem[wr_widx] <= wr_data_reg;
    end else if (store_go) begin
      mem[ctrl_widx] <= ctrl_new;
      if (rx_ok_reg) begin
        mem[res_widx] <= res_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_act_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      o_ud <= '0;
      o_ud_oe_n <= 1'b1;
      o_ack <= 1'b1;
    end else begin
      wr_act_reg <= wr_act;
      if (wr_act) begin
        wr_addr_reg <= i_ua;
        wr_data_reg <= i_ud;
      end
      o_ud <= (rd_act && rd_mapped) ? mem[rd_widx] : '0;
      o_ud_oe_n <= !rd_act;
      o_ack <= !(rd_act || wr_act);
    end
  end

  // R2 R14 third-miss pulse and request pin; a new request wins over reset.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pulse_cnt_reg <= '0;
      o_third_miss_pulse_pin <= 1'b0;
      o_satellite_request <= 1'b0;
    end else begin
      if (store_go && third_evt) begin
        pulse_cnt_reg <= scc_pkg::PULSE_CNT_W'(scc_pkg::THIRD_MISS_PULSE_CYC);
      end else if (pulse_busy) begin
        pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      end
      o_third_miss_pulse_pin <= (store_go && third_evt) || (pulse_cnt_reg > 8'h01);
      if (store_go && rx_satellite_request_flag_reg) begin
        o_satellite_request <= 1'b1;
      end else if (req_reset_wr) begin
        o_satellite_request <= 1'b0;
      end
    end
  end

  // R1 flag on third miss.
  third_miss_pulse_pin_set_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R1
    (store_go && !rx_ok_reg && ctrl_cur[13:12] == 2'h2) |-> ctrl_new[10])
    else $error("third miss did not set flag");
  // R1 no flag early.
  miss_early_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R1
    (store_go && !rx_ok_reg && ctrl_cur[13:12] == 2'h0) |-> !ctrl_new[10])
    else $error("third miss flag set on first miss");
  // R2 pulse stays high.
  pulse_start_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R2
    (store_go && third_evt) |=> o_third_miss_pulse_pin [*8])
    else $error("third miss pulse too short");
  // R2 pulse ends.
  pulse_end_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R2
    (pulse_cnt_reg == 8'h01 && !(store_go && third_evt)) |=> !o_third_miss_pulse_pin)
    else $error("third miss pulse too long");
  // R3 output word sent.
  tx_every_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R3
    (state_reg == scc_pkg::SCC_ISSUE) |=> (o_tx_valid && o_tx_do == $past(do_cur)))
    else $error("output word not sent");
  // R3 slot word held.
  tx_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R3
    o_tx_valid |=> ($stable(o_tx_do) && $stable(o_tx_sa)))
    else $error("slot word changed early");
  // R4 single store per slot.
  one_store_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R4
    store_go |=> !store_go)
    else $error("two stores in one slot");
  // R5 command eight mapping.
  area_map_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R5
    (store_go && o_tx_cmd == 4'h8) |-> (res_widx == scc_pkg::DI_BASE_W + {4'h0, sa_reg}))
    else $error("command 8 not mapped to input area");
  // R6 input area offset.
  di_offset_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R6
    (store_go && o_tx_cmd[2:0] == 3'h0) |-> (res_widx == ctrl_widx + 10'h080))
    else $error("input area not above control word");
  // R7 second area place.
  area_two_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R7
    (store_go && o_tx_cmd[2:0] == 3'h2) |-> (res_widx == 10'h100 + {4'h0, sa_reg}))
    else $error("second result area misplaced");
  // R7 seventh area place.
  area_seven_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R7
    (store_go && o_tx_cmd[2:0] == 3'h7) |-> (res_widx == 10'h240 + {4'h0, sa_reg}))
    else $error("seventh result area misplaced");
  // R8 auto-clear returns command.
  acf_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R8
    (store_go && rx_ok_reg && ctrl_cur[5:4] == 2'h1 && ctrl_cur[3:0] != 4'h0) |->
    (ctrl_new[4:0] == 5'h00))
    else $error("auto-clear did not return command");
  // R9 identity command returns.
  cmd7_done_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R9
    (store_go && rx_ok_reg && ctrl_cur[3:0] == 4'h7) |-> (ctrl_new[3:0] == 4'h0))
    else $error("identity command did not return");
  // R10 clear stores zero.
  clr_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R10
    (store_go && o_tx_cmd == 4'hB) |-> (res_wdata == 16'h0000))
    else $error("counter clear stored nonzero");
  // R11 round advances command.
  arf_step_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R11
    (store_go && rx_ok_reg && ctrl_cur[5:0] == 6'h22) |-> (ctrl_new[5:0] == 6'h23))
    else $error("auto-round did not advance");
  // R12 round then rest.
  round_rest_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R12
    (store_go && rx_ok_reg && ctrl_cur[5:0] == 6'h36) |-> (ctrl_new[5:0] == 6'h00))
    else $error("single round did not rest");
  // R13 R22 request flag set.
  req_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R13
    (store_go && rx_satellite_request_flag_reg) |-> ctrl_new[8])
    else $error("request flag not set");
  // R14 request pin reset.
  req_pin_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R14
    (req_reset_wr && !(store_go && rx_satellite_request_flag_reg)) |=> !o_satellite_request)
    else $error("request pin not reset");
  // R15 function clears request.
  req_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R15
    (store_go && rx_ok_reg && !rx_satellite_request_flag_reg && ctrl_cur[3:0] == 4'h7) |-> !ctrl_new[8])
    else $error("request flag not cleared");
  // R19 command field sent.
  cmd_field_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R19
    (state_reg == scc_pkg::SCC_ISSUE) |=> (o_tx_cmd == $past(ctrl_cur[3:0])))
    else $error("command field not sent");
  // R20 flags kept on miss.
  miss_keep_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R20
    (store_go && !rx_ok_reg) |-> (ctrl_new[5:0] == ctrl_cur[5:0]))
    else $error("command changed on a miss");
  // R21 round wraps to zero.
  arf_wrap_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R21
    (store_go && rx_ok_reg && ctrl_cur[5:0] == 6'h26) |-> (ctrl_new[5:0] == 6'h20))
    else $error("auto-round did not wrap");
endmodule // scc_center

// [hdl/scc_pkg.sv]
// Constants shared by the scan center command and status logic.
package scc_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned WIDX_W = 10;
  localparam int unsigned SA_W = 6;
  localparam int unsigned MEM_WORDS = 640;
  localparam logic [SA_W-1:0] SAT_LAST = 6'h3F;
  // Word indices of the areas; byte address is twice the index. REQ_RESET_ADDR is a byte address.
  localparam logic [WIDX_W-1:0] CTRL_BASE_W = 10'h000;
  localparam logic [WIDX_W-1:0] DO_BASE_W = 10'h040;
  localparam logic [WIDX_W-1:0] DI_BASE_W = 10'h080;
  localparam logic [ADDR_W-1:0] REQ_RESET_ADDR = 11'h480;
  localparam logic [7:0] REQ_RESET_DATA = 8'h00;
  // Control word layout.
  localparam int unsigned CMD_LSB = 0;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned ACF_BIT = 4;
  localparam int unsigned ARF_BIT = 5;
  localparam int unsigned SATELLITE_REQUEST_FLAG_BIT = 8;
  localparam int unsigned CHK1_BIT = 9;
  localparam int unsigned THIRD_MISS_PULSE_PIN_BIT = 10;
  localparam int unsigned MISS_LSB = 12;
  localparam int unsigned MISS_W = 2;
  localparam logic [MISS_W-1:0] MISS_THIRD = 2'h3;
  localparam logic [MISS_W-1:0] MISS_SECOND = 2'h2;
  // Commands.
  localparam logic [CMD_W-1:0] CMD_DI = 4'h0;
  localparam logic [CMD_W-1:0] CMD_DI_ALT = 4'h8;
  localparam logic [CMD_W-1:0] CMD_CNT_FIRST = 4'h1;
  localparam logic [CMD_W-1:0] CMD_CNT_LAST = 4'h6;
  localparam logic [CMD_W-1:0] CMD_SERIAL_ID = 4'h7;
  localparam logic [CMD_W-1:0] CMD_CLR_FIRST = 4'h9;
  localparam logic [CMD_W-1:0] CMD_CLR_LAST = 4'hE;
  localparam logic [WORD_W-1:0] CLEARED_WORD = 16'h0000;
  // Third-miss pulse time.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned THIRD_MISS_PULSE_NS = 1000;
  localparam int unsigned THIRD_MISS_PULSE_CYC =
    (THIRD_MISS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W = 8;
  typedef enum logic [3:0] {
    SCC_IDLE = 4'b0001,
    SCC_ISSUE = 4'b0010,
    SCC_WAIT = 4'b0100,
    SCC_STORE = 4'b1000
  } scc_state_e;
endpackage

// [hdl/scc_ctrl_update.sv]
// Next value of one satellite control word after a scan slot.
`timescale 1ns/10ps
module scc_ctrl_update (
  input wire logic [15:0] i_ctrl,
  input wire logic i_resp_ok,
  input wire logic i_resp_satellite_request_flag,
  output logic [15:0] o_ctrl,
  output logic o_third_event
);
  logic [3:0] cmd;
  logic acf;
  logic auto_round_flag;
  logic [1:0] miss;
  logic [3:0] cmd_new;
  logic acf_new;
  logic arf_new;
  logic [1:0] miss_new;
  logic once_only;
  logic is_func;

  assign cmd = i_ctrl[scc_pkg::CMD_LSB +: scc_pkg::CMD_W];
  assign acf = i_ctrl[scc_pkg::ACF_BIT];
  assign auto_round_flag = i_ctrl[scc_pkg::ARF_BIT];
  assign miss = i_ctrl[scc_pkg::MISS_LSB +: scc_pkg::MISS_W];
  assign once_only = cmd > scc_pkg::CMD_CNT_LAST;
  assign is_func = (cmd != scc_pkg::CMD_DI) && (cmd != scc_pkg::CMD_DI_ALT);
  assign miss_new = (miss == scc_pkg::MISS_THIRD) ? miss : miss + 2'h1;
  // R1 third miss detection.
  assign o_third_event = !i_resp_ok && (miss == scc_pkg::MISS_SECOND);

  always_comb begin
    cmd_new = cmd;
    acf_new = acf;
    arf_new = auto_round_flag;
    if (once_only) begin
      // R9 R10 one-shot commands return.
      cmd_new = scc_pkg::CMD_DI;
      acf_new = 1'b0;
    end else if (auto_round_flag) begin
      // R11 R12 R21 automatic round.
      if (cmd == scc_pkg::CMD_CNT_LAST) begin
        cmd_new = scc_pkg::CMD_DI;
        if (acf) begin
          acf_new = 1'b0;
          arf_new = 1'b0;
        end
      end else begin
        cmd_new = cmd + 4'h1;
      end
    end else if (acf && (cmd >= scc_pkg::CMD_CNT_FIRST)) begin
      // R8 R20 auto-clear after one execution.
      cmd_new = scc_pkg::CMD_DI;
      acf_new = 1'b0;
    end
  end

  always_comb begin
    o_ctrl = i_ctrl;
    if (i_resp_ok) begin
      o_ctrl[scc_pkg::CMD_LSB +: scc_pkg::CMD_W] = cmd_new;
      o_ctrl[scc_pkg::ACF_BIT] = acf_new;
      o_ctrl[scc_pkg::ARF_BIT] = arf_new;
      o_ctrl[scc_pkg::CHK1_BIT] = 1'b0;
      o_ctrl[scc_pkg::THIRD_MISS_PULSE_PIN_BIT] = 1'b0;
      o_ctrl[scc_pkg::MISS_LSB +: scc_pkg::MISS_W] = '0;
      // R13 R15 R22 request flag set or cleared.
      if (i_resp_satellite_request_flag) begin
        o_ctrl[scc_pkg::SATELLITE_REQUEST_FLAG_BIT] = 1'b1;
      end else if (is_func) begin
        o_ctrl[scc_pkg::SATELLITE_REQUEST_FLAG_BIT] = 1'b0;
      end
    end else begin
      o_ctrl[scc_pkg::CHK1_BIT] = 1'b1;
      // R1 third miss flag.
      o_ctrl[scc_pkg::THIRD_MISS_PULSE_PIN_BIT] = (miss_new == scc_pkg::MISS_THIRD);
      o_ctrl[scc_pkg::MISS_LSB +: scc_pkg::MISS_W] = miss_new;
    end
  end
endmodule // scc_ctrl_update

// [test/scc_sat_model.sv]
// Satellite stand-in that answers every issued slot after a short, varying wait.
`timescale 1ns/10ps
module scc_sat_model (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_tx_valid,
  input wire logic [5:0] i_tx_sa,
  input wire logic [3:0] i_tx_cmd,
  input wire logic [63:0] i_miss_mask,
  input wire logic [63:0] i_req_mask,
  output logic o_rx_done,
  output logic o_rx_ok,
  output logic [15:0] o_rx_data,
  output logic o_rx_satellite_request_flag
);
  logic busy;
  logic [1:0] wait_cnt;
  logic [15:0] word;
  logic answer;
  assign answer = busy && !i_tx_valid && (wait_cnt == 2'h0);
  assign word = (i_tx_cmd > 4'h8 && i_tx_cmd < 4'hF) ? 16'h0000 : {i_tx_cmd, 2'h2, i_tx_sa, 4'h5};
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy <= 1'b0;
      wait_cnt <= 2'h0;
      o_rx_done <= 1'b0;
      {o_rx_ok, o_rx_satellite_request_flag, o_rx_data} <= 18'h00000;
    end else begin
      o_rx_done <= answer;
      // Lines are not held between answers, so stale values cannot pass as fresh.
      o_rx_ok <= answer ? ~i_miss_mask[i_tx_sa] : ~o_rx_ok;
      o_rx_data <= answer ? word : ~o_rx_data;
      o_rx_satellite_request_flag <= answer ? i_req_mask[i_tx_sa] : ~o_rx_satellite_request_flag;
      if (i_tx_valid) begin
        busy <= 1'b1;
        wait_cnt <= i_tx_sa[1:0];
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // scc_sat_model

// [test/scc_center_tb.sv]
// Self-checking bench for the scan center with a behavioural memory model.
`timescale 1ns/10ps
module scc_center_tb;
  logic clk = 1'b0, rst = 1'b1, ucs_n = 1'b1, urd_n = 1'b1, uwr_n = 1'b1, run = 1'b0;
  logic [10:0] ua = 11'h000;
  logic [15:0] ud = 16'h0000, o_ud, tx_do, rx_data, rdat;
  logic [15:0] mem [640];
  logic oe_n, ack, txv, done, ok, dq, rdone, pulse, req, p_q = 1'b0, exp_req = 1'b0;
  logic [5:0] tx_sa, exp_sa = 6'h00;
  logic [3:0] tx_cmd;
  logic [63:0] miss = 64'h0, dmask = 64'h0;
  int failures = 0, total_checks = 0, seed = 32'hd3f0, rises = 0, hi = 0, exp_rises = 0, i;
  scc_center scc_center_i (.i_core_clk(clk), .i_sys_rst(rst), .i_ua(ua), .i_ud(ud),
    .o_ud(o_ud), .o_ud_oe_n(oe_n), .i_ucs_n(ucs_n), .i_urd_n(urd_n), .i_uwr_n(uwr_n),
    .o_ack(ack), .i_scan_run(run), .o_tx_valid(txv), .o_tx_sa(tx_sa), .o_tx_cmd(tx_cmd),
    .o_tx_do(tx_do), .i_rx_done(done), .i_rx_ok(ok), .i_rx_data(rx_data), .i_rx_satellite_request_flag(dq),
    .o_scan_read_done(rdone), .o_third_miss_pulse_pin(pulse), .o_satellite_request(req));
  scc_sat_model scc_sat_model_i (.i_core_clk(clk), .i_sys_rst(rst), .i_tx_valid(txv),
    .i_tx_sa(tx_sa), .i_tx_cmd(tx_cmd), .i_miss_mask(miss), .i_req_mask(dmask),
    .o_rx_done(done), .o_rx_ok(ok), .o_rx_data(rx_data), .o_rx_satellite_request_flag(dq));
  initial begin
    forever #5 clk = ~clk;
  end
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task hang;
    failures++;
    $display("wrong value at %0t: handshake never came", $time);
    results;
  endtask
  task wait_ack(input logic lvl);
    int n;
    for (n = 0; n < 20 && ack !== lvl; n++)
      @(posedge clk);
    if (ack !== lvl)
      hang;
  endtask
  task write_w(input logic [10:0] a, input logic [15:0] d);
    ua <= a;
    ud <= d;
    ucs_n <= 1'b0;
    uwr_n <= 1'b0;
    wait_ack(1'b0);
    ucs_n <= 1'b1;
    uwr_n <= 1'b1;
    wait_ack(1'b1);
    @(posedge clk);
    if (a == 11'h480) begin
      if (d[7:0] == 8'h00)
        exp_req = 1'b0;
    end else if (a[10:1] < 640)
      mem[a[10:1]] = d;
  endtask
  task read_w(input logic [10:0] a);
    ua <= a;
    ucs_n <= 1'b0;
    urd_n <= 1'b0;
    wait_ack(1'b0);
    rdat = o_ud;
    cmp({15'h0000, oe_n}, 16'h0000);
    ucs_n <= 1'b1;
    urd_n <= 1'b1;
    wait_ack(1'b1);
    @(posedge clk);
  endtask
  // Runs exactly one scan and leaves the scanner idle afterwards.
  task scan;
    int n;
    run <= 1'b1;
    for (n = 0; n < 3000 && !(txv === 1'b1 && tx_sa === 6'h3F); n++)
      @(posedge clk);
    run <= 1'b0;
    for (n = 0; n < 50 && rdone !== 1'b1; n++)
      @(posedge clk);
    if (rdone !== 1'b1)
      hang;
  endtask
  task automatic apply(input logic [5:0] sa, input logic k, input logic [15:0] d, input logic q);
    logic [15:0] c;
    c = mem[sa];
    if (k !== 1'b1) begin
      if (c[13:12] == 2'h2)
        exp_rises++;
      if (c[13:12] != 2'h3)
        c[13:12] = c[13:12] + 2'h1;
      c[10:9] = {c[13:12] == 2'h3, 1'b1};
    end else begin
      mem[128 + 64 * c[2:0] + sa] = (c[3:0] > 4'h8 && c[3:0] < 4'hF) ? 16'h0000 : d;
      if (q)
        exp_req = 1'b1;
      c[8] = q | (c[8] & (c[2:0] == 3'h0));
      c[13:12] = 2'h0;
      c[10:9] = 2'h0;
      if (c[3:0] > 4'h6)
        c[4:0] = 5'h00;
      else if (c[5])
        c[5:0] = (c[3:0] == 4'h6) ? {~c[4], 5'h00} : c[5:0] + 6'h01;
      else if (c[4] && c[3:0] != 4'h0)
        c[4:0] = 5'h00;
    end
    mem[sa] = c;
  endtask
  always @(posedge clk) begin
    if (txv === 1'b1) begin
      cmp({10'h000, tx_sa}, {10'h000, exp_sa});
      cmp({12'h000, tx_cmd}, {12'h000, mem[tx_sa][3:0]});
      cmp(tx_do, mem[64 + tx_sa]);
      exp_sa = exp_sa + 6'h01;
    end
    if (done === 1'b1)
      apply(tx_sa, ok, rx_data, dq);
    if (pulse === 1'b1)
      hi++;
    if (pulse === 1'b1 && p_q !== 1'b1)
      rises++;
    p_q = pulse;
  end
  initial begin
    #1000000;
    hang;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp({13'h0000, ack, oe_n, req}, 16'h0006);
    for (i = 0; i < 640; i++)
      write_w(11'(2 * i), (i < 64) ? 16'h0000 : 16'($random(seed)));
    for (i = 0; i < 16; i++)
      write_w(11'(32 + 2 * i), 16'(i));
    for (i = 4; i < 15; i++)
      write_w(11'(2 * i), 16'($random(seed)) & 16'h003F);
    write_w(11'h006, 16'h0011);
    write_w(11'h07A, 16'h0020);
    write_w(11'h050, 16'h0030);
    write_w(11'h07E, 16'h0009);
    write_w(11'h000, 16'h000F);
    miss[50] = 1'b1;
    dmask[15] = 1'b1;
    $display("test setup done");
    scan;
    cmp({15'h0000, req}, {15'h0000, exp_req});
    dmask[15] = 1'b0;
    write_w(11'h480, 16'h0101);
    cmp({15'h0000, req}, 16'h0001);
    write_w(11'h01E, 16'h0107);
    repeat (7) scan;
    $display("test scans done");
    write_w(11'h480, 16'h0000);
    cmp({15'h0000, req}, {15'h0000, exp_req});
    for (i = 0; i < 640; i++) begin
      read_w(11'(2 * i));
      cmp(rdat, mem[i]);
    end
    read_w(11'h500);
    cmp(rdat, 16'h0000);
    cmp(16'(rises), 16'(exp_rises));
    cmp(16'(hi), 16'(scc_pkg::THIRD_MISS_PULSE_CYC * exp_rises));
    $display("test readback done");
    results;
  end
endmodule // scc_center_tb
